// ### bench/sta_far_model.sv
// far side model: protection functions feeding the aggregator and an event buffer
`timescale 1ns/1ps
`default_nettype none
module sta_far_model
  import sta_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [CHAN_IN_W-1:0] start_req,
  input wire logic [CHAN_IN_W-1:0] trip_req,
  output logic [CHAN_IN_W-1:0] prot_start,
  output logic [CHAN_IN_W-1:0] prot_trip,
  input wire logic start_v,
  input wire logic start_on,
  input wire logic trip_v,
  input wire logic trip_on,
  output int n_on,
  output int n_off
);
  // protection stages register their own decisions, suppression stays inside them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_start <= '0;
      prot_trip <= '0;
    end else begin
      prot_start <= start_req;
      prot_trip <= trip_req;
    end
  end
  // event buffer only tallies stored on and off entries
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_on <= 0;
      n_off <= 0;
    end else begin
      n_on <= n_on + int'(start_v && start_on) + int'(trip_v && trip_on);
      n_off <= n_off + int'(start_v && !start_on) + int'(trip_v && !trip_on);
    end
  end
endmodule
`default_nettype wire

// ### bench/sta_top_tb.sv
// self-checking bench of the start and trip aggregator
`timescale 1ns/1ps
`default_nettype none
module sta_top_tb;
  import sta_pkg::*;
  localparam int MSC = 4;
  localparam int CWT = 2;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [15:0] FUNC_ENABLE = '0, SREQ = '0, TREQ = '0, PROT_START, PROT_TRIP;
  logic [3:0] XS = '0, XT = '0;
  logic FE = 1'b0, SCLR = 1'b0, TCLR = 1'b0;
  logic [1:0] FSEL = '0, SMASK = 2'h3, TMASK = 2'h3, CONDITION;
  logic [31:0] PROC_DATA = 32'h5a5a1234, EVT_TIME, EVT_DATA, TIME_MS, prev_ms;
  logic COMMON_START, COMMON_TRIP, SV, SON, TV, TON;
  logic [CWT-1:0] START_COUNT, TRIP_COUNT;
  int n_on, n_off, errors = 0, n_checks = 0;
  sta_top #(.CW(CWT), .MS_CYCLES(MSC)) i_sta_top (.MCLK(MCLK), .RST_N(RST_N),
    .PROT_START(PROT_START), .PROT_TRIP(PROT_TRIP), .FUNC_ENABLE(FUNC_ENABLE),
    .EXTRA_START_IN(XS), .EXTRA_TRIP_IN(XT), .STAGE_FORCE_EN(FE),
    .FORCED_STATE_SELECT(FSEL), .START_EVT_MASK(SMASK), .TRIP_EVT_MASK(TMASK),
    .START_CNT_CLR(SCLR), .TRIP_CNT_CLR(TCLR), .PROC_DATA(PROC_DATA),
    .COMMON_START(COMMON_START), .COMMON_TRIP(COMMON_TRIP), .CONDITION(CONDITION),
    .START_COUNT(START_COUNT), .TRIP_COUNT(TRIP_COUNT), .EVT_START_VALID(SV),
    .EVT_START_ON(SON), .EVT_TRIP_VALID(TV), .EVT_TRIP_ON(TON), .EVT_TIME(EVT_TIME),
    .EVT_DATA(EVT_DATA), .TIME_MS(TIME_MS));
  sta_far_model i_sta_far_model (.clk(MCLK), .rst_n(RST_N), .start_req(SREQ),
    .trip_req(TREQ), .prot_start(PROT_START), .prot_trip(PROT_TRIP), .start_v(SV),
    .start_on(SON), .trip_v(TV), .trip_on(TON), .n_on(n_on), .n_off(n_off));
  // clock and a copy of the stamp counter one edge old
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end
  always @(posedge MCLK) prev_ms <= TIME_MS;
  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  // protection inputs through the far side, events, stamp and snapshot
  task automatic s_prot();
    int i;
    int on0 = n_on;
    int off0 = n_off;
    @(posedge MCLK) begin FUNC_ENABLE <= 16'h0008; SREQ <= 16'h0004; end
    cyc(3);
    chk(COMMON_START === 1'b0, "disabled stage started");
    @(posedge MCLK) SREQ <= 16'h0008;
    for (i = 0; i < 20 && SV !== 1'b1; i++) cyc(1);
    if (i == 20) begin errors++; report_and_stop(); end
    chk(SON === 1'b1 && COMMON_START === 1'b1 && CONDITION === COND_START, "start");
    chk(EVT_TIME === prev_ms && EVT_DATA === 32'h5a5a1234, "stamp or snapshot");
    @(posedge MCLK) TREQ <= 16'h0008;
    cyc(2);
    chk(COMMON_TRIP === 1'b1 && CONDITION === COND_TRIP, "trip");
    @(posedge MCLK) begin SREQ <= '0; TREQ <= '0; end
    cyc(4);
    chk(n_on === on0 + 2 && n_off === off0 + 2, "event tally");
    i = TIME_MS;
    cyc(4 * MSC);
    chk(TIME_MS === i + 4, "ms count");
  endtask
  // every extra input bit drives its output
  task automatic s_extra();
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK) XS <= 4'h1 << i;
      cyc(1);
      chk(COMMON_START === 1'b1 && COMMON_TRIP === 1'b0, "extra start");
      @(posedge MCLK) begin XS <= '0; XT <= 4'h1 << i; end
      cyc(1);
      chk(COMMON_TRIP === 1'b1 && COMMON_START === 1'b0, "extra trip");
      @(posedge MCLK) XT <= '0;
    end
  endtask
  // forcing codes with and without permission
  task automatic s_force();
    logic [1:0] sel [5] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0] ec [5] = '{COND_NORMAL, COND_NORMAL, COND_START, COND_TRIP, COND_NORMAL};
    for (int k = 0; k < 5; k++) begin
      @(posedge MCLK) begin FE <= (k > 0); FSEL <= sel[k]; end
      cyc(2);
      chk(CONDITION === ec[k] && COMMON_TRIP === (ec[k] == COND_TRIP), "force");
      chk(COMMON_START === (ec[k] != COND_NORMAL), "force start");
    end
    @(posedge MCLK) begin FE <= 1'b0; FSEL <= '0; end
    cyc(2);
  endtask
  // each mask value on both outputs
  task automatic s_mask();
    for (int m = 0; m < 4; m++) begin
      @(posedge MCLK) begin SMASK <= m[1:0]; TMASK <= m[1:0]; XS <= 4'h2; XT <= 4'h8; end
      cyc(1);
      chk(SV === m[0] && TV === m[0], "on event mask");
      chk(TV !== 1'b1 || TON === 1'b1, "trip on level");
      @(posedge MCLK) begin XS <= '0; XT <= '0; end
      cyc(1);
      chk(SV === m[1] && TV === m[1], "off event mask");
      chk(TV !== 1'b1 || TON === 1'b0, "trip off level");
    end
  endtask
  // clear, saturation and clear racing a rise
  task automatic s_count();
    @(posedge MCLK) begin SCLR <= 1'b1; TCLR <= 1'b1; end
    @(posedge MCLK) begin SCLR <= 1'b0; TCLR <= 1'b0; end
    cyc(1);
    chk(START_COUNT === 2'h0 && TRIP_COUNT === 2'h0, "clear");
    repeat (4) begin
      @(posedge MCLK) XS <= 4'h4;
      @(posedge MCLK) XS <= 4'h0;
    end
    cyc(2);
    chk(START_COUNT === 2'h3, "saturate");
    @(posedge MCLK) begin TCLR <= 1'b1; XT <= 4'h1; end
    @(posedge MCLK) begin TCLR <= 1'b0; XT <= 4'h0; end
    cyc(1);
    chk(TRIP_COUNT === 2'h1, "clear with rise");
  endtask
  // reset, then the scenarios
  initial begin
    repeat (6) @(posedge MCLK);
    RST_N <= 1'b1;
    cyc(1);
    chk(COMMON_START === 1'b0 && START_COUNT === 2'h0, "reset state");
    s_prot();
    s_extra();
    s_force();
    s_mask();
    s_count();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### rtl/sta_chan.sv
// one combined output: level, masked on/off event and saturating counter
`timescale 1ns/1ps
`default_nettype none
module sta_chan
  import sta_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  sta_chan_if.chan ch
);
  typedef struct packed {
    logic lvl;
    logic evt_v;
    logic evt_on;
    logic [CW-1:0] cnt;
  } sta_chan_s;

  localparam logic [CW-1:0] CNT_MAX = '1;

  sta_chan_s st_r;
  sta_chan_s st_nxt;
  logic rise;
  logic fall;

  // edge detect, masked event and counter update
  always_comb begin
    st_nxt = st_r;
    rise = ch.lvl_nxt && !st_r.lvl;
    fall = !ch.lvl_nxt && st_r.lvl;
    st_nxt.lvl = ch.lvl_nxt;
    st_nxt.evt_on = ch.lvl_nxt;
    st_nxt.evt_v = (rise && ch.mask[MASK_ON_BIT]) || (fall && ch.mask[MASK_OFF_BIT]); // R4 R10
    if (rise) begin
      // a rise in the clear cycle still counts
      if (ch.clr) begin
        st_nxt.cnt = {{(CW-1){1'b0}}, 1'b1}; // R6
      end else if (st_r.cnt != CNT_MAX) begin
        st_nxt.cnt = st_r.cnt + 1'b1; // R13
      end
    end else if (ch.clr) begin
      st_nxt.cnt = '0; // R6
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ch.lvl = st_r.lvl;
  assign ch.evt_v = st_r.evt_v;
  assign ch.evt_on = st_r.evt_on;
  assign ch.cnt = st_r.cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_count_rise: assert property ($rose(st_r.lvl) && !$past(ch.clr) && $past(st_r.cnt) != CNT_MAX
    |-> st_r.cnt == $past(st_r.cnt) + 1'b1) else $error("counter did not step"); // R6 R13
  a_count_sat: assert property (st_r.cnt == CNT_MAX && !ch.clr |=> st_r.cnt == CNT_MAX)
    else $error("counter wrapped"); // R13
  a_count_clear: assert property (ch.clr && !rise |=> st_r.cnt == '0)
    else $error("counter not cleared"); // R6
endmodule
`default_nettype wire

// ### rtl/sta_chan_if.sv
// link between the aggregator top and one output channel
`timescale 1ns/1ps
`default_nettype none
interface sta_chan_if #(parameter int CW = 16);
  logic lvl_nxt;
  logic [1:0] mask;
  logic clr;
  logic lvl;
  logic evt_v;
  logic evt_on;
  logic [CW-1:0] cnt;
  modport drv (output lvl_nxt, output mask, output clr,
               input lvl, input evt_v, input evt_on, input cnt);
  modport chan (input lvl_nxt, input mask, input clr,
                output lvl, output evt_v, output evt_on, output cnt);
endinterface
`default_nettype wire

// ### rtl/sta_pkg.sv
// shared constants of the start and trip aggregator
package sta_pkg;
  // channel indices of the two combined outputs
  localparam int CH_START = 0;
  localparam int CH_TRIP = 1;
  localparam int NUM_CH = 2;
  // forced state selection codes
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_START = 2'h1;
  localparam logic [1:0] FORCE_TRIP = 2'h2;
  // block condition codes
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  // event mask field positions
  localparam int MASK_ON_BIT = 0;
  localparam int MASK_OFF_BIT = 1;
  // time stamp resolution and clock rate
  localparam int TS_RES_MS = 1;
  localparam int CLK_MHZ = 200;
  localparam int TS_RES_CYCLES = TS_RES_MS * 1000 * CLK_MHZ;
  // widths and reset values
  localparam int TIME_W = 32;
  localparam int CNT_W = 16;
  localparam int DATA_W = 32;
  localparam int CHAN_IN_W = 16;
  localparam int EXTRA_IN_W = 4;
  localparam logic [TIME_W-1:0] TIME_RST = 32'h0;
endpackage

// ### rtl/sta_top.sv
// start and trip aggregator with events, time stamps and counters
//
// Operation
// (R1) any enabled protection start drives the combined start, any enabled trip the trip.
// (R2) an active extra start input also drives the combined start.
// (R3) an active extra trip input also drives the combined trip.
// (R4) each change of either combined output gives an on or off event.
// (R5) each event carries a time stamp counted in one millisecond steps.
// (R6) each output has a cumulative event counter that can be cleared.
// (R7) forcing code 1 forces start, 2 forces trip, only while stage forcing is permitted.
// (R8) the condition code reads 0 normal, 1 start active, 2 trip active.
// (R9) there is no blocking input; suppression happens inside each protection function.
// (R10) a per-output mask selects whether on, off or both events are stored.
// (R11) each event carries a snapshot of process data taken at the change.
// (R12) the forcing selection is static and not touched by setting group changes.
// (R13) each counter steps by one on a rising output and saturates at its maximum.
`timescale 1ns/1ps
`default_nettype none
module sta_top
  import sta_pkg::*;
#(
  parameter int NF = CHAN_IN_W,
  parameter int NX = EXTRA_IN_W,
  parameter int CW = CNT_W,
  parameter int DW = DATA_W,
  parameter int MS_CYCLES = TS_RES_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [NF-1:0] PROT_START,
  input wire logic [NF-1:0] PROT_TRIP,
  input wire logic [NF-1:0] FUNC_ENABLE,
  input wire logic [NX-1:0] EXTRA_START_IN,
  input wire logic [NX-1:0] EXTRA_TRIP_IN,
  input wire logic STAGE_FORCE_EN,
  input wire logic [1:0] FORCED_STATE_SELECT,
  input wire logic [1:0] START_EVT_MASK,
  input wire logic [1:0] TRIP_EVT_MASK,
  input wire logic START_CNT_CLR,
  input wire logic TRIP_CNT_CLR,
  input wire logic [DW-1:0] PROC_DATA,
  output logic COMMON_START,
  output logic COMMON_TRIP,
  output logic [1:0] CONDITION,
  output logic [CW-1:0] START_COUNT,
  output logic [CW-1:0] TRIP_COUNT,
  output logic EVT_START_VALID,
  output logic EVT_START_ON,
  output logic EVT_TRIP_VALID,
  output logic EVT_TRIP_ON,
  output logic [TIME_W-1:0] EVT_TIME,
  output logic [DW-1:0] EVT_DATA,
  output logic [TIME_W-1:0] TIME_MS
);
  localparam int SUB_W = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(MS_CYCLES - 1);

  typedef struct packed {
    logic [SUB_W-1:0] sub;
    logic [TIME_W-1:0] ms;
    logic [TIME_W-1:0] stamp;
    logic [DW-1:0] data;
    logic [1:0] cond;
  } sta_top_s;

  sta_top_s st_r;
  sta_top_s st_nxt;
  logic agg_start;
  logic agg_trip;
  logic force_start;
  logic force_trip;
  logic start_nxt;
  logic trip_nxt;
  logic any_change;

  // one link per combined output
  sta_chan_if #(.CW(CW)) ch [NUM_CH] ();

  // per-output channel logic
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
      sta_chan #(.CW(CW)) u_chan (
        .clk(MCLK),
        .rst_n(RST_N),
        .ch(ch[gi].chan)
      );
    end
  endgenerate

  // aggregation of protection and extra inputs, no blocking term here
  always_comb begin
    agg_start = |(PROT_START & FUNC_ENABLE); // R1 R9
    agg_trip = |(PROT_TRIP & FUNC_ENABLE); // R1 R9
    agg_start = agg_start || (|EXTRA_START_IN); // R2
    agg_trip = agg_trip || (|EXTRA_TRIP_IN); // R3
  end

  // forcing is read straight from its static setting; no group input feeds it
  always_comb begin
    force_start = STAGE_FORCE_EN && (FORCED_STATE_SELECT == FORCE_START); // R7 R12
    force_trip = STAGE_FORCE_EN && (FORCED_STATE_SELECT == FORCE_TRIP); // R7 R12
  end

  // next levels of the combined outputs
  always_comb begin
    if (force_start) begin
      start_nxt = 1'b1; // R7
      trip_nxt = 1'b0;
    end else if (force_trip) begin
      start_nxt = 1'b1; // R7
      trip_nxt = 1'b1;
    end else begin
      start_nxt = agg_start;
      trip_nxt = agg_trip;
    end
    any_change = (start_nxt != ch[CH_START].lvl) || (trip_nxt != ch[CH_TRIP].lvl);
  end

  // channel control
  assign ch[CH_START].lvl_nxt = start_nxt;
  assign ch[CH_TRIP].lvl_nxt = trip_nxt;
  assign ch[CH_START].mask = START_EVT_MASK; // R10
  assign ch[CH_TRIP].mask = TRIP_EVT_MASK; // R10
  assign ch[CH_START].clr = START_CNT_CLR; // R6
  assign ch[CH_TRIP].clr = TRIP_CNT_CLR; // R6

  // millisecond clock, event snapshot and condition code
  always_comb begin
    st_nxt = st_r;
    if (st_r.sub == SUB_LAST) begin
      st_nxt.sub = '0;
      st_nxt.ms = st_r.ms + 32'h1; // R5
    end else begin
      st_nxt.sub = st_r.sub + 1'b1;
    end
    if (any_change) begin
      st_nxt.stamp = st_r.ms; // R5
      st_nxt.data = PROC_DATA; // R11
    end
    if (trip_nxt) begin
      st_nxt.cond = COND_TRIP; // R8
    end else if (start_nxt) begin
      st_nxt.cond = COND_START; // R8
    end else begin
      st_nxt.cond = COND_NORMAL; // R8
    end
  end

  // state register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r.sub <= '0;
      st_r.ms <= TIME_RST;
      st_r.stamp <= TIME_RST;
      st_r.data <= '0;
      st_r.cond <= COND_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs, all from flip-flops
  assign COMMON_START = ch[CH_START].lvl;
  assign COMMON_TRIP = ch[CH_TRIP].lvl;
  assign CONDITION = st_r.cond;
  assign START_COUNT = ch[CH_START].cnt;
  assign TRIP_COUNT = ch[CH_TRIP].cnt;
  assign EVT_START_VALID = ch[CH_START].evt_v; // R4
  assign EVT_START_ON = ch[CH_START].evt_on;
  assign EVT_TRIP_VALID = ch[CH_TRIP].evt_v; // R4
  assign EVT_TRIP_ON = ch[CH_TRIP].evt_on;
  assign EVT_TIME = st_r.stamp;
  assign EVT_DATA = st_r.data;
  assign TIME_MS = st_r.ms;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_start_any: assert property (|(PROT_START & FUNC_ENABLE) && !STAGE_FORCE_EN |=> COMMON_START)
    else $error("enabled start not aggregated"); // R1
  a_trip_any: assert property (|(PROT_TRIP & FUNC_ENABLE) && !STAGE_FORCE_EN |=> COMMON_TRIP)
    else $error("enabled trip not aggregated"); // R1
  a_idle_low: assert property (!STAGE_FORCE_EN && !(|(PROT_TRIP & FUNC_ENABLE))
    && !(|EXTRA_TRIP_IN) |=> !COMMON_TRIP) else $error("trip without cause"); // R1 R3
  a_extra_start: assert property (|EXTRA_START_IN |=> COMMON_START)
    else $error("extra start ignored"); // R2
  a_extra_trip: assert property (|EXTRA_TRIP_IN && !force_start |=> COMMON_TRIP)
    else $error("extra trip ignored"); // R3
  // the mask that counts is the one seen in the cycle before the output edge
  a_start_event: assert property (($rose(COMMON_START) && $past(START_EVT_MASK[MASK_ON_BIT]))
    || ($fell(COMMON_START) && $past(START_EVT_MASK[MASK_OFF_BIT]))
    |-> EVT_START_VALID && (EVT_START_ON == COMMON_START)) else $error("start event missing"); // R4
  a_trip_mask: assert property ($fell(COMMON_TRIP) && !$past(TRIP_EVT_MASK[MASK_OFF_BIT])
    |-> !EVT_TRIP_VALID) else $error("masked off event stored"); // R10
  a_no_spurious: assert property (EVT_TRIP_VALID |-> $changed(COMMON_TRIP))
    else $error("trip event without change"); // R4
  a_ms_step: assert property (st_r.sub == SUB_LAST |=> st_r.ms == $past(st_r.ms) + 32'h1)
    else $error("millisecond step wrong"); // R5
  a_stamp_take: assert property (EVT_START_VALID |-> EVT_TIME == $past(st_r.ms)
    && EVT_DATA == $past(PROC_DATA)) else $error("event snapshot wrong"); // R5 R11
  a_force_trip: assert property (STAGE_FORCE_EN && FORCED_STATE_SELECT == FORCE_TRIP
    |=> COMMON_TRIP && CONDITION == COND_TRIP) else $error("forced trip failed"); // R7
  a_force_start: assert property (STAGE_FORCE_EN && FORCED_STATE_SELECT == FORCE_START
    |=> COMMON_START && !COMMON_TRIP && CONDITION == COND_START)
    else $error("forced start failed"); // R7
  a_cond_code: assert property (CONDITION == (COMMON_TRIP ? COND_TRIP :
    (COMMON_START ? COND_START : COND_NORMAL))) else $error("condition code wrong"); // R8

  c_start_on: cover property ($rose(COMMON_START) && EVT_START_VALID);
  c_trip_off: cover property ($fell(COMMON_TRIP) && EVT_TRIP_VALID);
  c_both_evt: cover property (EVT_START_VALID && EVT_TRIP_VALID);
  c_forced: cover property (force_trip ##1 COMMON_TRIP);
endmodule
`default_nettype wire
